/* hw/function_select_regs.svh */
// register offsets, field positions, control codes and reset values
`ifndef FUNCTION_SELECT_REGS_SVH
`define FUNCTION_SELECT_REGS_SVH

`define ADR_CTRL 12'h000
`define ADR_Q 12'h004
`define ADR_CTLS 12'h008
`define ADR_PAL_PAGE 2'h1
`define ADR_ROM_PAGE 1'h1

`define CTRL_BUSY_BIT 0
`define CTRL_HOLD_BIT 1
`define CTRL_REFILL_BIT 2
`define CTRL_HOLD_RST 1'h0

`define ROM_DEPTH 512
`define PAL_DEPTH 256
`define CSW_BPC_BIT 4
`define PAL_RST 6'h38

`define SRC_AQ 3'h0
`define SRC_AB 3'h1
`define SRC_ZQ 3'h2
`define SRC_ZB 3'h3
`define SRC_ZA 3'h4
`define SRC_DA 3'h5
`define SRC_DQ 3'h6
`define SRC_D0 3'h7

`define FN_ADD 3'h0
`define FN_SUBR 3'h1
`define FN_SUBS 3'h2
`define FN_OR 3'h3
`define FN_AND 3'h4
`define FN_MASK 3'h5
`define FN_XOR 3'h6
`define FN_XNOR 3'h7

`define DST_LOADQ 3'h0
`define DST_NOP 3'h1
`define DST_WBA 3'h2
`define DST_WBF 3'h3
`define DST_RIGHT_SHIFT_BOTH 3'h4
`define DST_RIGHT_SHIFT_REGFILE_ONLY 3'h5
`define DST_LEFT_SHIFT_BOTH 3'h6
`define DST_LEFT_SHIFT_REGFILE_ONLY 3'h7

`endif

/* hw/function_select_pkg.sv */
// types shared by the slice decoder and the slice datapath
package function_select_pkg;

    typedef enum logic [2:0] {
        FMT_BASIC,
        FMT_MOVE,
        FMT_EXT,
        FMT_MEMREQ,
        FMT_MISC,
        FMT_JUMP,
        FMT_DECODE
    } uinst_fmt_t;

    typedef enum logic {
        ST_FILL,
        ST_RUN
    } fill_state_t;

    typedef struct packed {
        logic [2:0] src;
        logic [2:0] func;
        logic [2:0] dest;
        logic cin;
    } slice_ctl_t;

endpackage

/* hw/alu_slice_array.sv */
// bit-slice datapath: operand select, alu function, destination writes
`timescale 1ns/10ps
`include "function_select_regs.svh"
module alu_slice_array
    import function_select_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int REGS = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire slice_ctl_t ctl_i,
    input wire logic write_en_i,
    input wire logic [WIDTH-1:0] d_bus_i,
    input wire logic [$clog2(REGS)-1:0] a_addr_i,
    input wire logic [$clog2(REGS)-1:0] b_addr_i,
    input wire logic ram_shift_in_i,
    input wire logic q_shift_in_i,
    output logic [WIDTH-1:0] y_o,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] wr [REGS];
    logic [WIDTH-1:0] q;
    logic [WIDTH-1:0] a_data;
    logic [WIDTH-1:0] b_data;
    logic [WIDTH-1:0] r;
    logic [WIDTH-1:0] s;
    logic [WIDTH-1:0] f;
    logic [WIDTH-1:0] ram_in;
    logic ram_we;

    assign a_data = wr[a_addr_i];
    assign b_data = wr[b_addr_i];

    always_comb begin
        case (ctl_i.src)
            `SRC_AQ, `SRC_AB: r = a_data; // RQ3
            `SRC_ZQ, `SRC_ZB, `SRC_ZA: r = '0; // RQ4
            default: r = d_bus_i; // RQ5
        endcase
    end

    always_comb begin
        case (ctl_i.src)
            `SRC_AQ, `SRC_ZQ, `SRC_DQ: s = q; // RQ3
            `SRC_AB, `SRC_ZB: s = b_data; // RQ4
            `SRC_ZA, `SRC_DA: s = a_data; // RQ5
            default: s = '0;
        endcase
    end

    // subtraction is add of the complement, so no carry means minus one
    always_comb begin
        case (ctl_i.func)
            `FN_ADD: f = r + s + WIDTH'(ctl_i.cin); // RQ6
            `FN_SUBR: f = s + ~r + WIDTH'(ctl_i.cin); // RQ7
            `FN_SUBS: f = r + ~s + WIDTH'(ctl_i.cin); // RQ7
            `FN_OR: f = r | s; // RQ8
            `FN_AND: f = r & s;
            `FN_MASK: f = ~r & s;
            `FN_XOR: f = r ^ s;
            default: f = ~(r ^ s);
        endcase
    end

    always_comb begin
        case (ctl_i.dest)
            `DST_RIGHT_SHIFT_BOTH, `DST_RIGHT_SHIFT_REGFILE_ONLY:
                ram_in = {ram_shift_in_i, f[WIDTH-1:1]}; // RQ11
            `DST_LEFT_SHIFT_BOTH, `DST_LEFT_SHIFT_REGFILE_ONLY:
                ram_in = {f[WIDTH-2:0], ram_shift_in_i}; // RQ11
            default: ram_in = f; // RQ10
        endcase
    end

    assign ram_we = write_en_i && ctl_i.dest[2:1] != 2'h0; // RQ13

    always_ff @(posedge clk_i) begin
        if (ram_we) begin
            wr[b_addr_i] <= ram_in; // RQ21
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else if (write_en_i) begin
            case (ctl_i.dest)
                `DST_LOADQ: q <= f; // RQ9
                `DST_RIGHT_SHIFT_BOTH:
                    q <= {q_shift_in_i, q[WIDTH-1:1]}; // RQ12
                `DST_LEFT_SHIFT_BOTH:
                    q <= {q[WIDTH-2:0], q_shift_in_i}; // RQ12
                default: q <= q;
            endcase
        end
    end

    // y stays combinational so a store from y can finish in the same cycle
    assign y_o = (ctl_i.dest == `DST_WBA) ? a_data : f; // RQ14 RQ15
    assign q_o = q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence q_right_s;
        write_en_i && ctl_i.dest == `DST_RIGHT_SHIFT_BOTH;
    endsequence

    AST_R_ZERO: assert property ( // RQ4
        ctl_i.src inside {`SRC_ZQ, `SRC_ZB, `SRC_ZA} |-> r == '0)
        else $error("r not zero for zero source");
    AST_SUB_CARRY: assert property ( // RQ7
        ctl_i.func == `FN_SUBS && !ctl_i.cin |-> f == r - s - 1'b1)
        else $error("subtract without carry wrong");
    AST_Y_SEL: assert property ( // RQ14
        ctl_i.dest != `DST_WBA |-> y_o == f)
        else $error("y not alu result");
    AST_NOP_HOLD: assert property ( // RQ13
        ctl_i.dest == `DST_NOP |=> q == $past(q))
        else $error("q changed on nop");
    AST_LOADQ: assert property ( // RQ9
        write_en_i && ctl_i.dest == `DST_LOADQ |=> q == $past(f))
        else $error("q not loaded from alu");
    AST_Q_RIGHT: assert property ( // RQ12
        q_right_s |=> q[WIDTH-2:0] == $past(q[WIDTH-1:1]))
        else $error("q not shifted right");
endmodule

/* hw/alu_slice_control_decoder.sv */
// slice control decoder with lookup table, programmable logic and datapath
// What this block does
// RQ1: function bits and lowest destination bit come from a 512x4 table.
// RQ2: other six control bits come from programmable logic plus multiplier bit.
// RQ3: source 0 gives R=A, S=Q; source 1 gives R=A, S=B.
// RQ4: sources 2,3,4 zero R with S=Q,B,A; source 7 gives R=D, S=0.
// RQ5: source 5 gives R=D, S=A; source 6 gives R=D, S=Q.
// RQ6: functions 0,1,2 compute R+S, S-R, R-S.
// RQ7: carry adds one; without it subtraction yields difference minus one.
// RQ8: functions 3..7 are OR, AND, mask, XOR, XNOR; carry ignored.
// RQ9: destination 0 loads Q with result, keeps registers, outputs result.
// RQ10: destinations 2 and 3 write unshifted result into port-B register.
// RQ11: destinations 5 and 7 write right/left shifted result, Q untouched.
// RQ12: destinations 4 and 6 shift result into B and shift Q same way.
// RQ13: destination 1 loads nothing and holds every register.
// RQ14: Y carries result except destination 2, which drives port-A register.
// RQ15: destination 2 with a store from Y gives two transfers per cycle.
// RQ16: all controls derive from the nine top microinstruction bits.
// RQ17: multiplier low bit is an extra input altering extended operations.
// RQ18: basic and extended fields select 64 operations, move field eight.
// RQ19: decode puts D+1 on Y, writes it only when backup bit is one.
// RQ20: decoder produces the array carry input from the selected operation.
// RQ21: register writes land at cycle end; Y stays combinational.
`timescale 1ns/10ps
`include "function_select_regs.svh"
module alu_slice_control_decoder
    import function_select_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [8:0] control_store_word_i,
    input wire logic multiplier_low_bit_i,
    input wire logic [WIDTH-1:0] d_bus_i,
    input wire logic [3:0] wr_a_addr_i,
    input wire logic [3:0] wr_b_addr_i,
    input wire logic ram_shift_in_i,
    input wire logic q_shift_in_i,
    output logic [WIDTH-1:0] y_o
);
    localparam int ROM_AW = $clog2(`ROM_DEPTH);
    localparam int PAL_AW = $clog2(`PAL_DEPTH);

    // the table and the logic array are writable, so software owns
    // the operation set; a fill after reset gives safe contents
    logic [3:0] rom [`ROM_DEPTH];
    logic [5:0] pal [`PAL_DEPTH];

    fill_state_t st;
    logic [ROM_AW-1:0] fill_cnt;
    logic hold;
    logic busy;
    logic wr_stb;
    logic refill_req;
    logic write_en;
    uinst_fmt_t fmt;
    logic [PAL_AW-1:0] pal_idx;
    logic [5:0] pal_bits;
    logic [3:0] rom_bits;
    slice_ctl_t ctl;
    logic [WIDTH-1:0] q;
    logic [31:0] next_dat;

    // format of a microinstruction from its top nine bits
    function automatic uinst_fmt_t fmt_of(input logic [8:0] w);
        uinst_fmt_t k;
        if (w[8]) begin
            k = FMT_BASIC;
        end else if (w[7:6] == 2'h3) begin
            k = FMT_MOVE;
        end else if (w[7:6] == 2'h2) begin
            k = FMT_EXT;
        end else if (w[7:5] == 3'h3) begin
            k = FMT_MEMREQ;
        end else if (w[7:5] == 3'h2) begin
            k = FMT_MISC;
        end else if (w[7:5] == 3'h1) begin
            k = FMT_JUMP;
        end else begin
            k = FMT_DECODE;
        end
        return k;
    endfunction

    // default table word: add, low destination bit set for every format except misc
    function automatic logic [3:0] rom_default(input logic [8:0] w);
        return {`FN_ADD, fmt_of(w) != FMT_MISC};
    endfunction

    assign busy = (st == ST_FILL);
    assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
        && wb_sel_i[0];
    assign refill_req = wr_stb && wb_adr_i == `ADR_CTRL
        && wb_dat_i[`CTRL_REFILL_BIT];
    assign write_en = !busy && !hold;

    // fill sequencer: walks every table word once, then runs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= ST_FILL;
            fill_cnt <= '0;
        end else begin
            case (st)
                ST_FILL: begin
                    fill_cnt <= fill_cnt + 1'b1;
                    if (fill_cnt == ROM_AW'(`ROM_DEPTH - 1)) begin
                        st <= ST_RUN;
                    end
                end
                default: begin
                    if (refill_req) begin
                        st <= ST_FILL;
                        fill_cnt <= '0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (busy) begin
            rom[fill_cnt] <= rom_default(fill_cnt);
        end else if (wr_stb && wb_adr_i[11] == `ADR_ROM_PAGE) begin
            rom[wb_adr_i[ROM_AW+1:2]] <= wb_dat_i[3:0]; // RQ1
        end
    end

    always_ff @(posedge clk_i) begin
        if (busy) begin
            pal[fill_cnt[PAL_AW-1:0]] <= `PAL_RST;
        end else if (wr_stb && wb_adr_i[11:10] == `ADR_PAL_PAGE) begin
            pal[wb_adr_i[PAL_AW+1:2]] <= wb_dat_i[5:0]; // RQ2
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold <= `CTRL_HOLD_RST;
        end else if (wr_stb && wb_adr_i == `ADR_CTRL) begin
            hold <= wb_dat_i[`CTRL_HOLD_BIT];
        end
    end

    assign fmt = fmt_of(control_store_word_i); // RQ16

    always_comb begin
        case (fmt)
            FMT_BASIC: pal_idx = {2'h0, control_store_word_i[7:2]}; // RQ18
            FMT_MOVE: pal_idx = {5'h08, control_store_word_i[5:3]}; // RQ18
            FMT_EXT: pal_idx = {1'b1, control_store_word_i[5:0],
                multiplier_low_bit_i}; // RQ17
            default: pal_idx = '0;
        endcase
    end

    // formats with one fixed operation need no array entry
    always_comb begin
        case (fmt)
            FMT_BASIC, FMT_MOVE, FMT_EXT: pal_bits = pal[pal_idx]; // RQ2
            FMT_MEMREQ: pal_bits = {`SRC_D0, 2'h1, 1'b0};
            FMT_MISC: pal_bits = {`SRC_ZA, 2'h1, 1'b0};
            FMT_JUMP: pal_bits = {`SRC_D0, 2'h0, 1'b0};
            default: pal_bits = {`SRC_D0, 1'b0,
                control_store_word_i[`CSW_BPC_BIT], 1'b1}; // RQ19
        endcase
    end

    assign rom_bits = rom[control_store_word_i]; // RQ1

    always_comb begin
        ctl.src = pal_bits[5:3];
        ctl.func = rom_bits[3:1];
        ctl.dest = {pal_bits[2:1], rom_bits[0]};
        ctl.cin = pal_bits[0]; // RQ20
    end

    alu_slice_array #(
        .WIDTH(WIDTH),
        .REGS(16)
    ) u_array (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ctl_i(ctl),
        .write_en_i(write_en), // RQ21
        .d_bus_i(d_bus_i),
        .a_addr_i(wr_a_addr_i),
        .b_addr_i(wr_b_addr_i),
        .ram_shift_in_i(ram_shift_in_i),
        .q_shift_in_i(q_shift_in_i),
        .y_o(y_o),
        .q_o(q)
    );

    // read mux; unmapped words read as zero
    always_comb begin
        next_dat = '0;
        if (wb_adr_i == `ADR_CTRL) begin
            next_dat[`CTRL_BUSY_BIT] = busy;
            next_dat[`CTRL_HOLD_BIT] = hold;
        end else if (wb_adr_i == `ADR_Q) begin
            next_dat = 32'(q);
        end else if (wb_adr_i == `ADR_CTLS) begin
            next_dat[9:0] = ctl;
        end else if (wb_adr_i[11] == `ADR_ROM_PAGE) begin
            next_dat[3:0] = rom[wb_adr_i[ROM_AW+1:2]];
        end else if (wb_adr_i[11:10] == `ADR_PAL_PAGE) begin
            next_dat[5:0] = pal[wb_adr_i[PAL_AW+1:2]];
        end
    end

    // the bus waits out a fill instead of racing the sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !busy;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            wb_dat_o <= next_dat;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence wb_req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !busy;
    endsequence

    sequence wb_done_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    sequence decode_s;
        !busy && fmt == FMT_DECODE;
    endsequence

    AST_WB_ACK: assert property (wb_req_s |=> wb_done_s)
        else $error("bus ack not one cycle after request");
    AST_DECODE_CTL: assert property ( // RQ19
        decode_s |-> ctl.src == `SRC_D0 && ctl.cin
            && ctl.dest[2:1] == {1'b0, control_store_word_i[4]})
        else $error("decode controls wrong");
    AST_DECODE_Y: assert property ( // RQ19
        (decode_s and ctl.func == `FN_ADD) |-> y_o == d_bus_i + 1'b1)
        else $error("decode y not d plus one");
    AST_ROM_FUNC: assert property ( // RQ1
        wr_stb && wb_adr_i[11] && !hold ##1
            control_store_word_i == $past(wb_adr_i[ROM_AW+1:2])
            |-> ctl.func == $past(wb_dat_i[3:1], 1))
        else $error("function not from written table word");
    AST_MPLIER: assert property ( // RQ17
        fmt == FMT_EXT |-> pal_idx[0] == multiplier_low_bit_i)
        else $error("multiplier bit not in array index");
    AST_FILL_STEP: assert property (
        busy && fill_cnt != ROM_AW'(`ROM_DEPTH - 1)
            |=> busy && fill_cnt == $past(fill_cnt) + 1'b1)
        else $error("fill sequencer skipped");
    // watches the array's own q, so a broken gate is seen, not its input
    AST_HOLD_GATE: assert property (
        hold || busy |=> q == $past(q))
        else $error("array written while held");
endmodule

/* sim/ustore_model.sv */
// control store model presenting the current microinstruction word
`timescale 1ns/10ps
module ustore_model (
    input wire logic clk_i,
    input wire logic [8:0] next_word_i,
    output logic [8:0] control_store_word_o
);
    // registered like a real control store: a word set at one edge
    // reaches the decoder at the following edge
    always_ff @(posedge clk_i) begin
        control_store_word_o <= next_word_i;
    end
endmodule

/* sim/alu_slice_control_decoder_tb.sv */
// self-checking bench for the slice control decoder
`timescale 1ns/10ps
module alu_slice_control_decoder_tb;
    import function_select_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, mp, rsi, qsi, ack;
    logic [11:0] adr;
    logic [3:0] sel, a, b;
    logic [31:0] wdat, d, rd, q, dat_o, y;
    logic [31:0] wr [16];
    logic [8:0] next_word, csw;
    int err_total, comparisons;
    int cycles = 0;

    ustore_model ustore (.clk_i(clk_i), .next_word_i(next_word),
        .control_store_word_o(csw));
    alu_slice_control_decoder #(.WIDTH(32)) dut (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .control_store_word_i(csw),
        .multiplier_low_bit_i(mp), .d_bus_i(d), .wr_a_addr_i(a),
        .wr_b_addr_i(b), .ram_shift_in_i(rsi), .q_shift_in_i(qsi), .y_o(y));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            stop_test();
        end
    end

    task automatic stop_test();
        if (err_total == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // the first access after reset may wait out the table fill
    task automatic wb(input logic w, input logic [11:0] ad,
        input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        wdat <= wd;
        // ack and read data are taken at the edge that samples ack high
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            err_total++;
            stop_test();
        end
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic prog(input logic [8:0] w, input logic [7:0] ai,
        input logic [2:0] s, f, dst, input logic ci);
        wb(1'b1, 12'h400 + {2'h0, ai, 2'h0}, {26'h0, s, dst[2:1], ci});
        wb(1'b1, 12'h800 + {1'b0, w, 2'h0}, {28'h0, f, dst[0]});
    endtask

    function automatic logic [31:0] alu(input logic [2:0] s, f,
        input logic ci, input logic [31:0] ra, rb);
        logic [31:0] r, t;
        r = (s < 3'h2) ? ra : (s < 3'h5) ? 32'h0 : d;
        case (s)
            3'h0, 3'h2, 3'h6: t = q;
            3'h1, 3'h3: t = rb;
            3'h4, 3'h5: t = ra;
            default: t = 32'h0;
        endcase
        case (f)
            3'h0: return r + t + {31'h0, ci};
            3'h1: return t + ~r + {31'h0, ci};
            3'h2: return r + ~t + {31'h0, ci};
            3'h3: return r | t;
            3'h4: return r & t;
            3'h5: return ~r & t;
            3'h6: return r ^ t;
            default: return ~(r ^ t);
        endcase
    endfunction

    // one word for exactly one microcycle, then a jump word, which is a nop
    task automatic run(input logic [8:0] w, input logic [2:0] s, f, dst,
        input logic ci, input logic [31:0] dv, input logic [3:0] av, bv);
        logic [31:0] fv, rs, qs;
        @(posedge clk_i);
        next_word <= w;
        d <= dv;
        a <= av;
        b <= bv;
        @(posedge clk_i);
        next_word <= 9'h020;
        #1;
        fv = alu(s, f, ci, wr[av], wr[bv]);
        check("y", dst == 3'h2 ? wr[av] : fv, y);
        rs = dst[1] ? {fv[30:0], rsi} : {rsi, fv[31:1]};
        qs = dst[1] ? {q[30:0], qsi} : {qsi, q[31:1]};
        if (dst == 3'h0) begin
            q = fv;
        end else if (dst[2]) begin
            wr[bv] = rs;
            if (!dst[0]) begin
                q = qs;
            end
        end else if (dst != 3'h1) begin
            wr[bv] = fv;
        end
    endtask

    task automatic peek(input logic [3:0] bv);
        prog(9'h100, 8'h00, 3'h3, 3'h3, 3'h1, 1'b0);
        run(9'h100, 3'h3, 3'h3, 3'h1, 1'b0, 32'h0, 4'h0, bv);
    endtask

    task automatic chk_q();
        wb(1'b0, 12'h004, 32'h0);
        check("q", q, rd);
    endtask

    task automatic t_regs();
        // the jump word's own entry, so the next cycle decodes it at once
        wb(1'b1, 12'h880, 32'hffff_fff5);
        wb(1'b0, 12'h880, 32'h0);
        check("table", 32'h5, rd);
        wb(1'b1, 12'h7fc, 32'hffff_ffea);
        wb(1'b0, 12'h7fc, 32'h0);
        check("array", 32'h2a, rd);
        wb(1'b0, 12'h010, 32'h0);
        check("unmapped", 32'h0, rd);
    endtask

    task automatic t_init();
        prog(9'h100, 8'h00, 3'h7, 3'h0, 3'h3, 1'b0);
        for (int i = 0; i < 4; i++) begin
            run(9'h100, 3'h7, 3'h0, 3'h3, 1'b0, 32'ha5c3_0f96 ^ (i << 9),
                4'h0, i[3:0]);
        end
        prog(9'h100, 8'h00, 3'h7, 3'h0, 3'h0, 1'b0);
        run(9'h100, 3'h7, 3'h0, 3'h0, 1'b0, 32'h8000_0001, 4'h0, 4'h0);
        chk_q();
    endtask

    // decode word: D+1 on Y always, stored only with the backup bit set
    task automatic t_decode();
        for (int k = 0; k < 2; k++) begin
            run({4'h0, k[0], 4'h0}, 3'h7, 3'h0, k[0] ? 3'h3 : 3'h1, 1'b1,
                32'h1234_5678 + k, 4'h0, 4'h4);
        end
        peek(4'h4);
    endtask

    task automatic t_sweep();
        for (int k = 0; k < 128; k++) begin
            prog(9'h100, 8'h00, k[6:4], k[3:1], 3'h1, k[0]);
            run(9'h100, k[6:4], k[3:1], 3'h1, k[0], 32'h0f0f_3c3c, 4'h1,
                4'h2);
        end
    endtask

    // second pass aliases A and B so code 2 shows the old word on Y
    task automatic t_dest();
        for (int k = 0; k < 16; k++) begin
            prog(9'h100, 8'h00, 3'h1, 3'h0, k[2:0], k[3]);
            @(posedge clk_i);
            rsi <= k[3];
            qsi <= ~k[3];
            run(9'h100, 3'h1, 3'h0, k[2:0], k[3], 32'h0, 4'h3,
                k[3] ? 4'h3 : 4'h2);
            chk_q();
            peek(k[3] ? 4'h3 : 4'h2);
        end
    endtask

    task automatic t_mplier();
        prog(9'h085, 8'h8a, 3'h7, 3'h3, 3'h1, 1'b0);
        prog(9'h085, 8'h8b, 3'h4, 3'h3, 3'h1, 1'b0);
        run(9'h085, 3'h7, 3'h3, 3'h1, 1'b0, 32'h00c0_ffee, 4'h1, 4'h0);
        @(posedge clk_i);
        mp <= 1'b1;
        run(9'h085, 3'h4, 3'h3, 3'h1, 1'b0, 32'h00c0_ffee, 4'h1, 4'h0);
    endtask

    // hold blocks array writes; refill restores the default table words
    task automatic t_ctrl();
        logic [31:0] qk;
        qk = q;
        sel <= 4'he;
        wb(1'b1, 12'h000, 32'h2);
        sel <= 4'hf;
        wb(1'b0, 12'h000, 32'h0);
        check("sel", 32'h0, rd);
        wb(1'b1, 12'h000, 32'h2);
        wb(1'b0, 12'h000, 32'h0);
        check("ctrl", 32'h2, rd);
        prog(9'h100, 8'h00, 3'h7, 3'h0, 3'h0, 1'b0);
        run(9'h100, 3'h7, 3'h0, 3'h0, 1'b0, 32'h1357_9bdf, 4'h0, 4'h0);
        q = qk;
        chk_q();
        wb(1'b1, 12'h000, 32'h4);
        wb(1'b0, 12'h880, 32'h0);
        check("refill", 32'h1, rd);
        wb(1'b0, 12'h008, 32'h0);
        check("ctls", 32'h382, rd);
        wb(1'b0, 12'h000, 32'h0);
        check("ctrl", 32'h0, rd);
    endtask

    initial begin
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 12'h000;
        sel = 4'hf;
        wdat = 32'h0;
        d = 32'h0;
        a = 4'h0;
        b = 4'h0;
        mp = 1'b0;
        rsi = 1'b1;
        qsi = 1'b0;
        next_word = 9'h020;
        err_total = 0;
        comparisons = 0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_decode();
        t_init();
        t_sweep();
        t_dest();
        t_mplier();
        t_ctrl();
        stop_test();
    end
endmodule
